// >>> rtl/sbr_pkg.sv
// constants and types for the serial baud generator and receive error status
`default_nettype none
package sbr_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_ASYNC_MODE = 16'hff70;
  localparam logic [15:0] IDX_ERR_STAT = 16'hff71;
  localparam logic [15:0] IDX_SYNC_MODE = 16'hff72;
  localparam logic [15:0] IDX_BAUD_SEL = 16'hff73;
  localparam logic [15:0] IDX_RX_BUF = 16'hff74;
  localparam logic [7:0] REG_RESET = 8'h00;
  // writable bits of each control register
  localparam logic [7:0] ASYNC_WMASK = 8'hfc;
  localparam logic [7:0] SYNC_WMASK = 8'h86;
  localparam logic [7:0] BAUD_WMASK = 8'hf0;
  // async_mode_control fields
  localparam int ASM_TXE = 7;
  localparam int ASM_RXE = 6;
  localparam int ASM_PS_HI = 5;
  localparam int ASM_PS_LO = 4;
  localparam int ASM_CL = 3;
  localparam int ASM_SL = 2;
  // sync_mode_control fields
  localparam int SYM_CSIE = 7;
  localparam int SYM_DIR = 2;
  localparam int SYM_CSCK = 1;
  // receive_error_status fields
  localparam int ERR_PE = 2;
  localparam int ERR_FE = 1;
  localparam int ERR_OVE = 0;
  // baud_clock_select source field
  localparam int BSEL_HI = 7;
  localparam int BSEL_LO = 4;
  localparam logic [3:0] BSEL_MAX_INT = 4'h7;
  localparam logic [3:0] BSEL_EXT = 4'h8;
  // parity modes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  // generator ticks per bit, then data bits per character
  localparam logic [4:0] TICKS_INT = 5'h08;
  localparam logic [4:0] TICKS_EXT = 5'h10;
  localparam logic [3:0] LEN_SHORT = 4'h7;
  localparam logic [3:0] LEN_LONG = 4'h8;
  typedef enum logic [1:0] {SBR_STOP, SBR_ASYNC, SBR_SYNC} sbr_mode_e;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } sbr_rx_e;
endpackage : sbr_pkg
`default_nettype wire

// >>> rtl/sbr_top.sv
// serial baud generator, mode decode and receive error status
// How it works
// - error status valid in asynchronous mode only
// - status clears on reset, read only
// - bit 2 set on parity mismatch
// - bit 1 set on missing stop bit
// - receiver checks just one stop bit
// - bit 0 set when buffer unread
// - unread buffer keeps flagging overrun each reception
// - clock select chooses source, resets to zero
// - codes 0-7 give main clock over 2^(n+1)
// - code 8 uses external pin, others prohibited
// - internal bit rate clock/2^(n+2)/8
// - external bit rate pin frequency/16
// - 3-wire shift clock is clock/2^(n+2)
// - external shift clock ignores clock select
// - three modes: stop, UART, 3-wire
// - stop mode: no transfer, pins are ports
// - stop set by both mode registers
`default_nettype none
module sbr_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic async_rx_pin,
  input wire logic ext_baud_clock_pin,
  input wire logic sync_shift_run,
  output logic sync_shift_clock_out,
  output logic sync_shift_clock_oe_n,
  output logic baud_tick,
  output logic pins_as_ports,
  output sbr_pkg::sbr_mode_e serial_mode
);
  import sbr_pkg::*;

  function automatic logic hit(input logic [17:0] adr,
                               input logic [15:0] idx);
    hit = (adr == {idx, 2'b00});
  endfunction : hit

  function automatic logic [8:0] div_mask(input logic [3:0] n);
    div_mask = 9'((10'h001 << n) - 10'h001);
  endfunction : div_mask

  logic [7:0] async_mode_control_q;
  logic [7:0] sync_mode_control_q;
  logic [7:0] baud_clock_select_q;
  logic [7:0] receive_error_status_q;
  logic [7:0] receive_buffer_q;
  logic rx_full_q;
  logic ack_q;
  logic [31:0] rdata_q;
  sbr_mode_e mode_q;
  logic [8:0] div_q;
  logic ext_prev_q;
  logic sck_q;
  logic sck_oe_n_q;
  logic tick_q;
  logic ports_q;
  sbr_rx_e rx_q;
  logic [4:0] tcnt_q;
  logic [3:0] bits_q;
  logic [7:0] shift_q;
  logic par_bit_q;
  logic done_q;
  logic fe_q;

  // bus access decode
  logic acc;
  logic wr;
  logic rd_buf;
  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign rd_buf = acc && !wb_we_i && hit(wb_adr_i, IDX_RX_BUF);

  // source decode
  logic [3:0] src;
  logic ext_src;
  logic int_src;
  logic [3:0] n_val;
  logic [8:0] m_half;
  logic [8:0] m_full;
  logic half_stb;
  logic full_stb;
  logic ext_edge;
  logic gen_tick;
  logic [4:0] tpb;
  assign src = baud_clock_select_q[BSEL_HI:BSEL_LO];
  assign ext_src = (src == BSEL_EXT);
  assign int_src = (src <= BSEL_MAX_INT);
  assign n_val = src + 4'h1;
  assign m_half = div_mask(n_val);
  assign m_full = div_mask(n_val + 4'h1);
  assign half_stb = int_src && ((div_q & m_half) == m_half);
  assign full_stb = int_src && ((div_q & m_full) == m_full);
  assign ext_edge = ext_src && ext_baud_clock_pin && !ext_prev_q;
  // ticks run only in UART mode; prohibited codes give none
  assign gen_tick = (mode_q == SBR_ASYNC) && (full_stb || ext_edge);
  assign tpb = ext_src ? TICKS_EXT : TICKS_INT;

  // wishbone slave: one wait state, ack for one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc) begin
      rdata_q <= 32'h0000_0000;
      if (hit(wb_adr_i, IDX_ASYNC_MODE)) begin
        rdata_q[7:0] <= async_mode_control_q;
      end else if (hit(wb_adr_i, IDX_ERR_STAT)) begin
        rdata_q[7:0] <= receive_error_status_q;
      end else if (hit(wb_adr_i, IDX_SYNC_MODE)) begin
        rdata_q[7:0] <= sync_mode_control_q;
      end else if (hit(wb_adr_i, IDX_BAUD_SEL)) begin
        rdata_q[7:0] <= baud_clock_select_q;
      end else if (hit(wb_adr_i, IDX_RX_BUF)) begin
        rdata_q[7:0] <= receive_buffer_q;
      end
    end
  end

  // control registers; stop set by both mode registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      async_mode_control_q <= REG_RESET;
      sync_mode_control_q <= REG_RESET;
      baud_clock_select_q <= REG_RESET;
    end else if (wr) begin
      if (hit(wb_adr_i, IDX_ASYNC_MODE)) begin
        async_mode_control_q <= wb_dat_i[7:0] & ASYNC_WMASK;
      end
      if (hit(wb_adr_i, IDX_SYNC_MODE)) begin
        sync_mode_control_q <= wb_dat_i[7:0] & SYNC_WMASK;
      end
      if (hit(wb_adr_i, IDX_BAUD_SEL)) begin
        baud_clock_select_q <= wb_dat_i[7:0] & BAUD_WMASK;
      end
    end
  end

  // mode decode; prohibited mixes fall back to stop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_q <= SBR_STOP;
    end else if (!async_mode_control_q[ASM_TXE] &&
                 !async_mode_control_q[ASM_RXE] &&
                 !sync_mode_control_q[SYM_CSIE]) begin
      mode_q <= SBR_STOP;
    end else if (sync_mode_control_q[SYM_CSIE]) begin
      mode_q <= (async_mode_control_q[ASM_TXE] ||
                 async_mode_control_q[ASM_RXE]) ?
                SBR_STOP : SBR_SYNC;
    end else begin
      mode_q <= SBR_ASYNC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ports_q <= 1'b1;
    end else begin
      ports_q <= (mode_q == SBR_STOP);
    end
  end

  // prescaler restarts when the source is rewritten
  always_ff @(posedge sys_clk) begin
    if (reset || mode_q == SBR_STOP) begin
      div_q <= 9'h000;
    end else if (wr && hit(wb_adr_i, IDX_BAUD_SEL)) begin
      div_q <= 9'h000;
    end else begin
      div_q <= div_q + 9'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_baud_clock_pin;
      tick_q <= gen_tick;
    end
  end

  // 3-wire shift clock, driven only with internal clock selected
  logic sync_int;
  assign sync_int = (mode_q == SBR_SYNC) &&
                    sync_mode_control_q[SYM_CSCK];
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sck_q <= 1'b1;
      sck_oe_n_q <= 1'b1;
    end else begin
      sck_oe_n_q <= !sync_int;
      if (!sync_int || !sync_shift_run) begin
        sck_q <= 1'b1;
      end else if (half_stb) begin
        sck_q <= !sck_q;
      end
    end
  end

  // receiver; samples the middle of each bit
  logic rx_on;
  logic samp;
  logic [3:0] len;
  logic [1:0] ps;
  assign rx_on = (mode_q == SBR_ASYNC) && async_mode_control_q[ASM_RXE];
  assign len = async_mode_control_q[ASM_CL] ? LEN_LONG : LEN_SHORT;
  assign ps = async_mode_control_q[ASM_PS_HI:ASM_PS_LO];
  assign samp = gen_tick && (rx_q == RX_START ?
                tcnt_q == ((tpb >> 1) - 5'h01) : tcnt_q == (tpb - 5'h01));

  always_ff @(posedge sys_clk) begin
    if (reset || !rx_on) begin
      rx_q <= RX_IDLE;
      tcnt_q <= 5'h00;
      bits_q <= 4'h0;
      shift_q <= 8'h00;
      par_bit_q <= 1'b0;
      fe_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (samp) begin
        tcnt_q <= 5'h00;
      end else if (gen_tick) begin
        tcnt_q <= tcnt_q + 5'h01;
      end
      unique case (rx_q)
        RX_IDLE: begin
          tcnt_q <= 5'h00;
          bits_q <= 4'h0;
          shift_q <= 8'h00;
          if (!async_rx_pin) begin
            rx_q <= RX_START;
          end
        end
        RX_START: begin
          if (samp) begin
            rx_q <= async_rx_pin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (samp) begin
            shift_q[bits_q[2:0]] <= async_rx_pin;
            bits_q <= bits_q + 4'h1;
            if (bits_q + 4'h1 == len) begin
              rx_q <= (ps == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (samp) begin
            par_bit_q <= async_rx_pin;
            rx_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (samp) begin
            fe_q <= !async_rx_pin;
            done_q <= 1'b1;
            rx_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // completion: buffer load or overrun, error flags per character
  logic full_eff;
  logic pe_now;
  assign full_eff = rx_full_q && !rd_buf;
  assign pe_now = ps[1] &&
                  ((^shift_q ^ par_bit_q) != (ps == PAR_ODD));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_full_q <= 1'b0;
      receive_buffer_q <= 8'h00;
    end else if (done_q && !full_eff) begin
      rx_full_q <= 1'b1;
      receive_buffer_q <= shift_q;
    end else if (rd_buf) begin
      rx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      receive_error_status_q <= REG_RESET;
    end else if (done_q) begin
      receive_error_status_q[ERR_PE] <= pe_now;
      receive_error_status_q[ERR_FE] <= fe_q;
      receive_error_status_q[ERR_OVE] <= full_eff;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign sync_shift_clock_out = sck_q;
  assign sync_shift_clock_oe_n = sck_oe_n_q;
  assign baud_tick = tick_q;
  assign pins_as_ports = ports_q;
  assign serial_mode = mode_q;

  a_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");
  a_status_read_only: assert property (@(posedge sys_clk)
    disable iff (reset)
    (wr && hit(wb_adr_i, IDX_ERR_STAT) && !done_q) |=>
    $stable(receive_error_status_q))
    else $error("status register changed by a write");
  a_status_reset: assert property (@(posedge sys_clk)
    reset |=> receive_error_status_q == REG_RESET)
    else $error("status not cleared by reset");
  a_select_reset: assert property (@(posedge sys_clk)
    reset |=> baud_clock_select_q == REG_RESET)
    else $error("clock select not cleared by reset");
  a_overrun_flag: assert property (@(posedge sys_clk) disable iff (reset)
    (done_q && rx_full_q && !rd_buf) |=>
    receive_error_status_q[ERR_OVE] && $stable(receive_buffer_q))
    else $error("overrun not flagged or buffer overwritten");
  a_ext_tick_rate: assert property (@(posedge sys_clk) disable iff (reset)
    (gen_tick && ext_src) |-> (ext_baud_clock_pin && !ext_prev_q))
    else $error("external tick without a pin edge");
  a_int_tick_align: assert property (@(posedge sys_clk)
    disable iff (reset)
    (gen_tick && int_src) |-> (div_q[0] == 1'b1))
    else $error("internal tick off the divider");
  a_ext_sck_idle: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_q == SBR_SYNC && !sync_mode_control_q[SYM_CSCK]) |=>
    sck_oe_n_q && sck_q)
    else $error("shift clock driven with external clock");
  a_stop_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_q == SBR_STOP) |=> (rx_q == RX_IDLE) && !tick_q &&
    ports_q)
    else $error("activity in stop mode");
endmodule : sbr_top
`default_nettype wire

// >>> testbench/sbr_uart_partner.sv
// remote asynchronous sender driving the receive line
`default_nettype none
module sbr_uart_partner #(
  parameter int BIT_CYC = 64
) (
  input wire logic sys_clk,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_line = 1'b1;
  // start, eight data bits lsb first, parity, one stop, idle bits
  task automatic send(input logic [7:0] d, input logic par,
                      input logic stp, input int idle);
    logic [10:0] f;
    f = {stp, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge sys_clk);
      rx_line <= f[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
    if (idle > 0) begin
      @(posedge sys_clk);
      rx_line <= 1'b1;
      repeat (idle * BIT_CYC - 1) @(posedge sys_clk);
    end
  endtask : send
endmodule : sbr_uart_partner
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the baud generator and error status
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbr_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [17:0] wb_adr_i = 18'h0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  wire logic rx;
  logic ext_pin = 1'b0;
  logic run = 1'b0;
  logic sck;
  logic sck_oe_n;
  logic baud_tick;
  logic pins_as_ports;
  sbr_mode_e serial_mode;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int t;
  int g;
  always #2.5 sys_clk = ~sys_clk;
  sbr_top dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .async_rx_pin(rx), .ext_baud_clock_pin(ext_pin),
    .sync_shift_run(run), .sync_shift_clock_out(sck),
    .sync_shift_clock_oe_n(sck_oe_n), .baud_tick(baud_tick),
    .pins_as_ports(pins_as_ports), .serial_mode(serial_mode));
  sbr_uart_partner u_p (.sys_clk(sys_clk), .rx_line(rx));
  task automatic results();
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [15:0] idx,
                    input logic [7:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask : wb
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, idx, d, r);
  endtask : wr
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] e);
    logic [31:0] r;
    wb(1'b0, idx, 8'h00, r);
    chk(r, {24'h0, e});
  endtask : rdchk
  // ticks seen and shift clock changes over a window
  task automatic cnt(input int cyc);
    logic p;
    t = 0;
    g = 0;
    p = sck;
    repeat (cyc) begin
      @(posedge sys_clk);
      t += (baud_tick === 1'b1);
      g += (sck !== p);
      p = sck;
    end
  endtask : cnt
  task automatic t_regs();
    rdchk(IDX_ERR_STAT, 8'h00);
    rdchk(IDX_BAUD_SEL, 8'h00);
    chk(32'(serial_mode), 32'(SBR_STOP));
    chk(pins_as_ports, 1'b1);
    wr(IDX_ERR_STAT, 8'hff);
    rdchk(IDX_ERR_STAT, 8'h00);
    wr(IDX_BAUD_SEL, 8'ha5);
    rdchk(IDX_BAUD_SEL, 8'ha0);
    rdchk(16'hff75, 8'h00);
    wr(IDX_BAUD_SEL, 8'h10);
    cnt(256);
    chk(t, 0);
  endtask : t_regs
  task automatic t_async_clk();
    wr(IDX_ASYNC_MODE, 8'h6c);
    cnt(2);
    chk(32'(serial_mode), 32'(SBR_ASYNC));
    chk(pins_as_ports, 1'b0);
    for (int k = 1; k < 8; k++) begin
      wr(IDX_BAUD_SEL, 8'(k << 4));
      cnt(2048);
      chk(t, 2048 >> (k + 2));
    end
    wr(IDX_BAUD_SEL, 8'h90);
    cnt(512);
    chk(t, 0);
    wr(IDX_BAUD_SEL, 8'h80);
    fork
      cnt(200);
      repeat (20) begin
        repeat (4) @(posedge sys_clk);
        ext_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext_pin <= 1'b0;
      end
    join
    chk(t, 20);
  endtask : t_async_clk
  task automatic t_rx();
    wr(IDX_BAUD_SEL, 8'h10);
    u_p.send(8'h55, 1'b1, 1'b1, 1);
    rdchk(IDX_ERR_STAT, 8'h00);
    rdchk(IDX_RX_BUF, 8'h55);
    u_p.send(8'h55, 1'b0, 1'b1, 1);
    rdchk(IDX_ERR_STAT, 8'h04);
    rdchk(IDX_RX_BUF, 8'h55);
    u_p.send(8'h01, 1'b0, 1'b1, 1);
    rdchk(IDX_ERR_STAT, 8'h00);
    u_p.send(8'h03, 1'b1, 1'b1, 1);
    rdchk(IDX_ERR_STAT, 8'h01);
    u_p.send(8'h07, 1'b0, 1'b1, 0);
    u_p.send(8'h0f, 1'b1, 1'b1, 1);
    rdchk(IDX_ERR_STAT, 8'h01);
    rdchk(IDX_RX_BUF, 8'h01);
    u_p.send(8'h1f, 1'b0, 1'b1, 1);
    rdchk(IDX_ERR_STAT, 8'h00);
    rdchk(IDX_RX_BUF, 8'h1f);
    // seven data bits, even parity; top bit of d is the parity bit
    wr(IDX_ASYNC_MODE, 8'h74);
    u_p.send(8'hc1, 1'b1, 1'b1, 1);
    rdchk(IDX_ERR_STAT, 8'h04);
    rdchk(IDX_RX_BUF, 8'h41);
    wr(IDX_ASYNC_MODE, 8'h6c);
    u_p.send(8'h3f, 1'b1, 1'b0, 2);
    rdchk(IDX_ERR_STAT, 8'h02);
  endtask : t_rx
  task automatic t_sync();
    wr(IDX_ASYNC_MODE, 8'h00);
    wr(IDX_SYNC_MODE, 8'h82);
    run <= 1'b1;
    cnt(2);
    chk(32'(serial_mode), 32'(SBR_SYNC));
    chk(sck_oe_n, 1'b0);
    for (int k = 0; k < 8; k++) begin
      wr(IDX_BAUD_SEL, 8'(k << 4));
      cnt(256);
      chk(g, 256 >> (k + 1));
    end
    run <= 1'b0;
    cnt(2);
    cnt(64);
    chk(g, 0);
    chk(sck, 1'b1);
    wr(IDX_SYNC_MODE, 8'h80);
    cnt(64);
    chk(g, 0);
    chk({sck, sck_oe_n}, 2'h3);
    wr(IDX_SYNC_MODE, 8'h00);
    cnt(2);
    chk(32'(serial_mode), 32'(SBR_STOP));
    chk(pins_as_ports, 1'b1);
  endtask : t_sync
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_async_clk();
    t_rx();
    t_sync();
    results();
  end
endmodule : tb
`default_nettype wire
